// ===== rtl/tcmp_pkg.sv
package tcmp_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CMP_A = 8'h0c;
  localparam logic [7:0] ADDR_CMP_B = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_FLAG = 8'h18;
  // ==========================================================
  // control_reg_a fields
  localparam int WGM_LO_POS = 0;
  localparam int COM_B_POS = 4;
  localparam int COM_A_POS = 6;
  // control_reg_b fields
  localparam int CS_POS = 0;
  localparam int WGM_HI_POS = 3;
  localparam int FOC_B_POS = 6;
  localparam int FOC_A_POS = 7;
  // flag and mask bit positions
  localparam int OVF_POS = 0;
  localparam int CMPA_POS = 1;
  localparam int CMPB_POS = 2;
  // ==========================================================
  // counter extremes and reset values
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ==========================================================
  // waveform modes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA = 3'h5;
  localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  // compare output modes
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcmp_pkg

// ===== rtl/tcmp_core.sv
`timescale 1ns/1ns
// Operation
// - count and two compare values, 8-bit
// - three flags shown, each individually masked
// - tick from prescaler or external pin edge
// - clock select zero stops counter
// - tick clears, increments or decrements counter
// - cpu reads/writes count any time
// - cpu count write beats count/clear
// - mode: two bits ctrl a, one ctrl b
// - bottom at 0x00, max 0xff, top selectable
// - overflow flag set per mode
// - match sets compare flag next tick
// - flag masked to irq, cleared by one/ack
// - waveform from match, mode, output mode
// - pwm modes double-buffer compare values
// - cpu reaches buffer when buffered
// - force strobe forces match in non-pwm
// - forced match only updates wave output
// - count write blocks next tick match
// - normal mode wraps, overflow at zero
// - ctc clears at compare a match
// - output mode zero leaves output alone
// - reset clears output states
module tcmp_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_input,
  input wire logic [2:0] irq_ack,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic timer_irq
);
  // ==========================================================
  // state
  typedef struct packed {
    logic aw_q;
    logic [7:0] awaddr_q;
    logic w_q;
    logic [7:0] wdata_q;
    logic wstb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] ctrl_a_q;
    logic [3:0] ctrl_b_q;
    logic [7:0] count_q;
    logic [7:0] cmp_a_q;
    logic [7:0] cmp_b_q;
    logic [7:0] buf_a_q;
    logic [7:0] buf_b_q;
    logic [2:0] mask_q;
    logic [2:0] flag_q;
    logic dir_down_q;
    logic block_q;
    logic [1:0] match_q;
    logic [9:0] presc_q;
    logic ext_q;
    logic wave_a_q;
    logic wave_b_q;
    logic irq_q;
  } tcmp_state_t;
  tcmp_state_t s_q, s_d;
  logic [2:0] wgm, cs;
  logic pwm, tick, m_a, m_b, top_hit, bot_hit, wr_go, wr_count;
  logic [7:0] top_val;
  logic [1:0] com_a, com_b;
  // ==========================================================
  // decode of mode, tick and compare
  always_comb begin
    wgm = {s_q.ctrl_b_q[tcmp_pkg::WGM_HI_POS],
           s_q.ctrl_a_q[tcmp_pkg::WGM_LO_POS +: 2]};
    cs = s_q.ctrl_b_q[tcmp_pkg::CS_POS +: 3];
    com_a = s_q.ctrl_a_q[tcmp_pkg::COM_A_POS +: 2];
    com_b = s_q.ctrl_a_q[tcmp_pkg::COM_B_POS +: 2];
    pwm = wgm[0]; // pwm modes are the odd codes, 4 and 6 act as normal
    // tick source and edge select
    unique case (cs)
      tcmp_pkg::CS_STOP: tick = 1'b0;
      tcmp_pkg::CS_DIV1: tick = 1'b1;
      tcmp_pkg::CS_DIV8: tick = &s_q.presc_q[2:0];
      tcmp_pkg::CS_DIV64: tick = &s_q.presc_q[5:0];
      tcmp_pkg::CS_DIV256: tick = &s_q.presc_q[7:0];
      tcmp_pkg::CS_DIV1024: tick = &s_q.presc_q;
      tcmp_pkg::CS_EXT_FALL: tick = s_q.ext_q & ~ext_count_input;
      default: tick = ~s_q.ext_q & ext_count_input;
    endcase
    // top is max or compare a
    top_val = (wgm == tcmp_pkg::WGM_CTC || wgm[2]) ? s_q.cmp_a_q
                                                    : tcmp_pkg::MAX;
    top_hit = s_q.count_q == top_val;
    bot_hit = s_q.count_q == tcmp_pkg::BOTTOM;
    m_a = (s_q.count_q == s_q.cmp_a_q) && !s_q.block_q;
    m_b = (s_q.count_q == s_q.cmp_b_q) && !s_q.block_q;
    wr_go = s_q.aw_q && s_q.w_q && !s_q.bvalid_q;
    wr_count = wr_go && s_q.wstb_q
               && s_q.awaddr_q == tcmp_pkg::ADDR_COUNT;
  end

  // wave update per unit: set, clear or toggle
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic up, input logic pwm_m,
                                     input logic hit, input logic frc,
                                     input logic at_top, input logic at_bot);
    logic r;
    r = cur;
    if (!pwm_m) begin
      if (hit || frc) begin
        unique case (com)
          tcmp_pkg::COM_NONE: r = cur;
          tcmp_pkg::COM_TOGGLE: r = ~cur;
          tcmp_pkg::COM_CLEAR: r = 1'b0;
          default: r = 1'b1;
        endcase
      end
    end else if (com[1]) begin
      // non-inverted for com 2, inverted for com 3
      if (hit) r = up ? com[0] : ~com[0];
      else if (at_bot) r = ~com[0];
      else if (at_top && !up) r = ~com[0];
    end
    return r;
  endfunction : wave_next

  // ==========================================================
  // next state
  always_comb begin
    logic [7:0] wd;
    logic up_now, frc_a, frc_b;
    logic [2:0] set_v, clr_v;
    wd = s_q.wdata_q;
    up_now = !s_q.dir_down_q;
    frc_a = 1'b0;
    frc_b = 1'b0;
    set_v = 3'h0;
    clr_v = 3'h0;
    s_d = s_q;
    s_d.presc_q = s_q.presc_q + 10'h001;
    s_d.ext_q = ext_count_input;
    // axi write channels taken in either order
    if (s_axi_awvalid && !s_q.aw_q) begin
      s_d.aw_q = 1'b1;
      s_d.awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_q) begin
      s_d.w_q = 1'b1;
      s_d.wdata_q = s_axi_wdata[7:0];
      s_d.wstb_q = s_axi_wstrb[0];
    end
    if (s_q.bvalid_q && s_axi_bready) s_d.bvalid_q = 1'b0;
    if (s_q.rvalid_q && s_axi_rready) s_d.rvalid_q = 1'b0;
    // counter operation on tick
    if (tick) begin
      s_d.block_q = 1'b0;
      s_d.match_q = {m_b, m_a};
      if (m_a) set_v[tcmp_pkg::CMPA_POS] = 1'b1;
      if (m_b) set_v[tcmp_pkg::CMPB_POS] = 1'b1;
      unique case (wgm)
        tcmp_pkg::WGM_PC_MAX, tcmp_pkg::WGM_PC_OCRA: begin
          if (top_hit) begin
            s_d.dir_down_q = 1'b1;
            s_d.count_q = s_q.count_q - 8'h01;
            s_d.cmp_a_q = s_q.buf_a_q;
            s_d.cmp_b_q = s_q.buf_b_q;
          end else if (bot_hit && s_q.dir_down_q) begin
            s_d.dir_down_q = 1'b0;
            s_d.count_q = s_q.count_q + 8'h01;
            set_v[tcmp_pkg::OVF_POS] = 1'b1;
          end else begin
            s_d.count_q = s_q.dir_down_q ? s_q.count_q - 8'h01
                                         : s_q.count_q + 8'h01;
          end
        end
        tcmp_pkg::WGM_FAST_MAX, tcmp_pkg::WGM_FAST_OCRA,
        tcmp_pkg::WGM_CTC: begin
          s_d.dir_down_q = 1'b0;
          if (top_hit) begin
            s_d.count_q = tcmp_pkg::BOTTOM;
            if (pwm) begin
              set_v[tcmp_pkg::OVF_POS] = 1'b1;
              s_d.cmp_a_q = s_q.buf_a_q;
              s_d.cmp_b_q = s_q.buf_b_q;
            end
          end else begin
            s_d.count_q = s_q.count_q + 8'h01;
          end
          if (!pwm && s_q.count_q == tcmp_pkg::MAX)
            set_v[tcmp_pkg::OVF_POS] = 1'b1;
        end
        default: begin
          s_d.dir_down_q = 1'b0;
          s_d.count_q = s_q.count_q + 8'h01;
          if (s_q.count_q == tcmp_pkg::MAX)
            set_v[tcmp_pkg::OVF_POS] = 1'b1;
        end
      endcase
      s_d.wave_a_q = wave_next(s_q.wave_a_q, com_a, up_now, pwm, m_a,
                               1'b0, top_hit, bot_hit);
      s_d.wave_b_q = wave_next(s_q.wave_b_q, com_b, up_now, pwm, m_b,
                               1'b0, top_hit, bot_hit);
    end
    if (!pwm) begin
      s_d.cmp_a_q = s_q.buf_a_q;
      s_d.cmp_b_q = s_q.buf_b_q;
    end
    // register write
    if (wr_go) begin
      s_d.aw_q = 1'b0;
      s_d.w_q = 1'b0;
      s_d.bvalid_q = 1'b1;
      s_d.bresp_q = tcmp_pkg::RESP_OKAY;
      if (s_q.wstb_q) begin
        unique case (s_q.awaddr_q)
          tcmp_pkg::ADDR_CTRL_A: s_d.ctrl_a_q = wd;
          tcmp_pkg::ADDR_CTRL_B: begin
            s_d.ctrl_b_q = {wd[tcmp_pkg::WGM_HI_POS], wd[2:0]};
            frc_a = wd[tcmp_pkg::FOC_A_POS] && !pwm;
            frc_b = wd[tcmp_pkg::FOC_B_POS] && !pwm;
          end
          tcmp_pkg::ADDR_COUNT: begin
            s_d.count_q = wd;
            s_d.block_q = 1'b1;
          end
          tcmp_pkg::ADDR_CMP_A: s_d.buf_a_q = wd;
          tcmp_pkg::ADDR_CMP_B: s_d.buf_b_q = wd;
          tcmp_pkg::ADDR_MASK: s_d.mask_q = wd[2:0];
          tcmp_pkg::ADDR_FLAG: clr_v = wd[2:0];
          default: s_d.bresp_q = tcmp_pkg::RESP_SLVERR;
        endcase
      end
    end
    // forced match: wave only, no flag, no counter change
    if (frc_a)
      s_d.wave_a_q = wave_next(s_d.wave_a_q, com_a, 1'b1, 1'b0, 1'b0,
                               1'b1, 1'b0, 1'b0);
    if (frc_b)
      s_d.wave_b_q = wave_next(s_d.wave_b_q, com_b, 1'b1, 1'b0, 1'b0,
                               1'b1, 1'b0, 1'b0);
    // read channel
    if (s_axi_arvalid && !s_q.rvalid_q) begin
      s_d.rvalid_q = 1'b1;
      s_d.rresp_q = tcmp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        tcmp_pkg::ADDR_CTRL_A: s_d.rdata_q = {24'h0, s_q.ctrl_a_q};
        tcmp_pkg::ADDR_CTRL_B: s_d.rdata_q = {28'h0, s_q.ctrl_b_q};
        tcmp_pkg::ADDR_COUNT: s_d.rdata_q = {24'h0, s_q.count_q};
        tcmp_pkg::ADDR_CMP_A: s_d.rdata_q = {24'h0, s_q.buf_a_q};
        tcmp_pkg::ADDR_CMP_B: s_d.rdata_q = {24'h0, s_q.buf_b_q};
        tcmp_pkg::ADDR_MASK: s_d.rdata_q = {29'h0, s_q.mask_q};
        tcmp_pkg::ADDR_FLAG: s_d.rdata_q = {29'h0, s_q.flag_q};
        default: begin
          s_d.rdata_q = 32'h0;
          s_d.rresp_q = tcmp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // ack or write-one clears; a same-cycle hardware set wins
    s_d.flag_q = (s_q.flag_q & ~irq_ack & ~clr_v) | set_v;
    s_d.irq_q = |(s_d.flag_q & s_d.mask_q);
  end

  // ==========================================================
  // registers, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  always_comb begin
    s_axi_awready = !s_q.aw_q;
    s_axi_wready = !s_q.w_q;
  end
  assign s_axi_bvalid = s_q.bvalid_q;
  assign s_axi_bresp = s_q.bresp_q;
  assign s_axi_arready = !s_q.rvalid_q;
  assign s_axi_rvalid = s_q.rvalid_q;
  assign s_axi_rdata = s_q.rdata_q;
  assign s_axi_rresp = s_q.rresp_q;
  assign wave_out_a = s_q.wave_a_q;
  assign wave_out_b = s_q.wave_b_q;
  assign timer_irq = s_q.irq_q;

  // ==========================================================
  // checks
  a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    cs == tcmp_pkg::CS_STOP && !wr_count |=> $stable(s_q.count_q))
    else $error("counter moved while stopped");
  a_write_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_count |=> s_q.count_q == $past(s_q.wdata_q))
    else $error("count write lost");
  a_block_match: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_count |=> !m_a && !m_b)
    else $error("match not blocked after count write");
  a_normal_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && wgm == tcmp_pkg::WGM_NORMAL && s_q.count_q == 8'hff
    && !wr_go |=> s_q.flag_q[0] && s_q.count_q == 8'h00)
    else $error("normal wrap wrong");
  a_ctc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && wgm == tcmp_pkg::WGM_CTC && top_hit && !wr_go
    |=> s_q.count_q == 8'h00)
    else $error("ctc clear missing");
  a_cmp_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && m_a && irq_ack == 3'h0 |=> s_q.flag_q[1])
    else $error("compare flag not set");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_irq |-> $past(|(s_d.flag_q & s_d.mask_q)))
    else $error("irq without masked flag");
  a_com_none: assert property (@(posedge aclk) disable iff (!aresetn)
    com_a == tcmp_pkg::COM_NONE && !pwm && !wr_go
    |=> $stable(s_q.wave_a_q))
    else $error("wave a changed with no action");

  // ==========================================================
  // count, flag, buffer and force checks
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && wgm == tcmp_pkg::WGM_NORMAL && !wr_go
    |=> s_q.count_q == $past(s_q.count_q) + 8'h01)
    else $error("count did not step up on tick");
  a_flag_b_set: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && m_b |=> s_q.match_q[1] && s_q.flag_q[tcmp_pkg::CMPB_POS])
    else $error("compare b flag not set");
  a_ack_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick && irq_ack[tcmp_pkg::CMPA_POS]
    |=> !s_q.flag_q[tcmp_pkg::CMPA_POS])
    else $error("serviced flag not cleared");
  a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s_q.wstb_q && s_q.awaddr_q == tcmp_pkg::ADDR_FLAG
    && s_q.wdata_q[2:0] == 3'h0 && irq_ack == 3'h0
    |=> (s_q.flag_q & $past(s_q.flag_q)) == $past(s_q.flag_q))
    else $error("zero write cleared a flag");
  a_buf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm && !tick |=> $stable(s_q.cmp_a_q) && $stable(s_q.cmp_b_q))
    else $error("buffered compare changed off a tick");
  a_force_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s_q.wstb_q && s_q.awaddr_q == tcmp_pkg::ADDR_CTRL_B
    && s_q.wdata_q[tcmp_pkg::FOC_A_POS] && !pwm && !tick
    && com_a == tcmp_pkg::COM_TOGGLE
    |=> s_q.wave_a_q != $past(s_q.wave_a_q))
    else $error("forced toggle missing");
  a_force_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s_q.wstb_q && s_q.awaddr_q == tcmp_pkg::ADDR_CTRL_B
    && !tick && irq_ack == 3'h0
    |=> $stable(s_q.flag_q) && $stable(s_q.count_q))
    else $error("forced match touched flag or count");
endmodule : tcmp_core

// ===== dv/eight_bit_timer_compare_core_bench.sv
`timescale 1ns/1ns
// ==========================================================
// comparison macro
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== 32'(ex)) begin \
    err_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, 32'(ex), got); \
  end \
end

module eight_bit_timer_compare_core_bench;
  // ==========================================================
  // stimulus, observation and model state
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ext_in = 1'b0;
  logic [2:0] irq_ack = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic wave_out_a, wave_out_b, timer_irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int err_count = 0;
  int n_checks = 0;
  int cnt = 0, act_a = 0, act_b = 0, buf_a = 0, buf_b = 0, blk = 0;
  int flags = 0, mask = 0, wave_a = 0, wave_b = 0, ctl_a = 0, ctl_b = 0;

  tcmp_core i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_count_input(ext_in), .irq_ack(irq_ack),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .timer_irq(timer_irq)
  );

  // free running 10 MHz clock
  always #50 aclk = ~aclk;

  // ==========================================================
  // reference model
  function automatic int pwm();
    return ctl_a & 1;
  endfunction : pwm

  function automatic int com_do(int c, int w);
    case (c)
      1: return w ^ 1;
      2: return 0;
      3: return 1;
      default: return w;
    endcase
  endfunction : com_do

  function automatic void m_tick();
    int ha, hb, old;
    ha = (cnt == act_a) && (blk == 0);
    hb = (cnt == act_b) && (blk == 0);
    blk = 0;
    if (ha) flags |= 2;
    if (hb) flags |= 4;
    if (ha && !pwm()) wave_a = com_do((ctl_a >> 6) & 3, wave_a);
    if (hb && !pwm()) wave_b = com_do((ctl_a >> 4) & 3, wave_b);
    old = cnt;
    cnt = ((ctl_a & 3) == 2 && ha) ? 0 : (cnt + 1) % 256;
    if (old == 255 && cnt == 0) begin
      flags |= 1;
      if (pwm()) {act_a, act_b} = {buf_a, buf_b};
    end
  endfunction : m_tick

  function automatic void m_write(logic [7:0] a, int v);
    case (a)
      tcmp_pkg::ADDR_CTRL_A: ctl_a = v;
      tcmp_pkg::ADDR_CTRL_B: begin
        ctl_b = v & 8'h0f;
        if (v[7] && !pwm()) wave_a = com_do((ctl_a >> 6) & 3, wave_a);
        if (v[6] && !pwm()) wave_b = com_do((ctl_a >> 4) & 3, wave_b);
      end
      tcmp_pkg::ADDR_COUNT: begin
        cnt = v;
        blk = 1;
      end
      tcmp_pkg::ADDR_CMP_A: {buf_a, act_a} = {v, pwm() ? act_a : v};
      tcmp_pkg::ADDR_CMP_B: {buf_b, act_b} = {v, pwm() ? act_b : v};
      tcmp_pkg::ADDR_MASK: mask = v & 7;
      tcmp_pkg::ADDR_FLAG: flags &= ~v;
      default: ;
    endcase
  endfunction : m_write

  function automatic int m_read(logic [7:0] a);
    case (a)
      tcmp_pkg::ADDR_CTRL_A: return ctl_a;
      tcmp_pkg::ADDR_CTRL_B: return ctl_b;
      tcmp_pkg::ADDR_COUNT: return cnt;
      tcmp_pkg::ADDR_CMP_A: return buf_a;
      tcmp_pkg::ADDR_CMP_B: return buf_b;
      tcmp_pkg::ADDR_MASK: return mask;
      tcmp_pkg::ADDR_FLAG: return flags;
      default: return 0;
    endcase
  endfunction : m_read

  // ==========================================================
  // bus master tasks
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] v,
                        output logic [1:0] rs);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, v};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      #1;
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] rs);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      #1;
      ah = arvalid && arready;
      rh = rvalid && rready;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask : axi_rd

  // register write and checked read
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    axi_wr(a, v, r);
    `CHK("bresp", tcmp_pkg::RESP_OKAY, r);
    m_write(a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    axi_rd(a, d, r);
    `CHK("rresp", tcmp_pkg::RESP_OKAY, r);
    `CHK("rdata", m_read(a), d);
  endtask : rd

  // external pin pulses, one timer tick each when selected
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk) ext_in <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_in <= 1'b0;
      repeat (4) @(posedge aclk);
      if ((ctl_b & 7) >= 6) m_tick();
    end
  endtask : ticks

  task automatic chk_out();
    repeat (2) @(posedge aclk);
    #1;
    `CHK("wave_out_a", wave_a, wave_out_a);
    `CHK("wave_out_b", wave_b, wave_out_b);
    `CHK("timer_irq", (flags & mask) != 0, timer_irq);
  endtask : chk_out

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge aclk);
    err_count++;
    $display("watchdog expired");
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(47637));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4) rd(8'(a));
    chk_out();
    axi_rd(8'h1c, d, r);
    `CHK("unmapped rresp", tcmp_pkg::RESP_SLVERR, r);
    `CHK("unmapped rdata", 0, d);
    axi_wr(8'h1c, 8'h55, r);
    `CHK("unmapped bresp", tcmp_pkg::RESP_SLVERR, r);
    done("reset");
    wr(tcmp_pkg::ADDR_CTRL_B, 8'h07);
    wr(tcmp_pkg::ADDR_CMP_A, 8'hff);
    wr(tcmp_pkg::ADDR_CMP_B, 8'(8'h20 + $urandom_range(63)));
    wr(tcmp_pkg::ADDR_COUNT, 8'hfe);
    ticks(3);
    rd(tcmp_pkg::ADDR_COUNT);
    rd(tcmp_pkg::ADDR_FLAG);
    rd(tcmp_pkg::ADDR_CMP_B);
    chk_out();
    wr(tcmp_pkg::ADDR_CTRL_B, 8'h00);
    wr(tcmp_pkg::ADDR_COUNT, 8'($urandom_range(255)));
    ticks(2);
    rd(tcmp_pkg::ADDR_COUNT);
    done("normal");
    wr(tcmp_pkg::ADDR_FLAG, 8'h00);
    rd(tcmp_pkg::ADDR_FLAG);
    wr(tcmp_pkg::ADDR_MASK, 8'h02);
    chk_out();
    wr(tcmp_pkg::ADDR_FLAG, 8'h01);
    rd(tcmp_pkg::ADDR_FLAG);
    @(posedge aclk) irq_ack <= 3'h2;
    @(posedge aclk) irq_ack <= 3'h0;
    flags &= ~2;
    rd(tcmp_pkg::ADDR_FLAG);
    chk_out();
    done("flags");
    wr(tcmp_pkg::ADDR_CTRL_B, 8'h07);
    wr(tcmp_pkg::ADDR_CMP_B, 8'h40);
    wr(tcmp_pkg::ADDR_COUNT, 8'h40);
    ticks(1);
    rd(tcmp_pkg::ADDR_FLAG);
    wr(tcmp_pkg::ADDR_COUNT, 8'h3f);
    ticks(2);
    rd(tcmp_pkg::ADDR_FLAG);
    done("blocking");
    wr(tcmp_pkg::ADDR_FLAG, 8'h07);
    wr(tcmp_pkg::ADDR_CTRL_B, 8'h06);
    wr(tcmp_pkg::ADDR_CTRL_A, 8'h42);
    wr(tcmp_pkg::ADDR_CMP_A, 8'h03);
    wr(tcmp_pkg::ADDR_COUNT, 8'h00);
    ticks(7);
    rd(tcmp_pkg::ADDR_COUNT);
    rd(tcmp_pkg::ADDR_FLAG);
    chk_out();
    done("clear on match");
    wr(tcmp_pkg::ADDR_FLAG, 8'h07);
    for (int c = 0; c < 4; c++) begin
      wr(tcmp_pkg::ADDR_CTRL_A, 8'((c << 6) | (c << 4) | 2));
      wr(tcmp_pkg::ADDR_CTRL_B, 8'hc6);
      chk_out();
      rd(tcmp_pkg::ADDR_FLAG);
    end
    rd(tcmp_pkg::ADDR_COUNT);
    done("force");
    wr(tcmp_pkg::ADDR_CTRL_A, 8'h03);
    wr(tcmp_pkg::ADDR_CMP_A, 8'h12);
    rd(tcmp_pkg::ADDR_CMP_A);
    wr(tcmp_pkg::ADDR_COUNT, 8'h10);
    ticks(3);
    rd(tcmp_pkg::ADDR_FLAG);
    wr(tcmp_pkg::ADDR_COUNT, 8'hfe);
    ticks(2);
    wr(tcmp_pkg::ADDR_FLAG, 8'h07);
    wr(tcmp_pkg::ADDR_COUNT, 8'h10);
    ticks(3);
    rd(tcmp_pkg::ADDR_FLAG);
    done("buffering");
    stop_test();
  end
endmodule : eight_bit_timer_compare_core_bench
